// ---- hdl/jtpd_pkg.sv ----
// types for the jtag programming data path
package jtpd_pkg;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SH_DR,
    TAP_EX1_DR,
    TAP_PA_DR,
    TAP_EX2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SH_IR,
    TAP_EX1_IR,
    TAP_PA_IR,
    TAP_EX2_IR,
    TAP_UPD_IR
  } jtpd_tap_t;

endpackage

// ---- hdl/jtpd_regs.svh ----
// constants for the jtag programming data path
// Notes on behaviour
// (RL1) reset instruction selects one-bit reset chain
// (RL2) reset chain shifts on tck in shift-dr
// (RL3) reset chain one holds device in reset
// (RL4) unlatched reset, then fuse-selected time-out after clear
// (RL5) programmer resets device before entering programming
// (RL6) unlock instruction shifts 16-bit key register
// (RL7) update-dr compares key, enters programming on match
// (RL8) fixed unlock key is 1010 0011 0111 0000
// (RL9) key register cleared at power-on reset
// (RL10) command instruction selects 15-bit command register
// (RL11) capture-dr loads previous command result
// (RL12) shift-dr shifts result out, command in
// (RL13) update-dr applies command to memory control
// (RL14) run-test/idle pass gives one execute clock
// (RL15) all chains shift least significant bit first
// (RL16) page fill chain moves each byte to buffer
// (RL17) page fill: only shift-dr has effect; capture-dr here also restarts the bit and byte counters
// (RL18) page dump chain is page plus eight bits
// (RL19) page dump reads bytes out, ignores tdi
// (RL20) page chains only when device first in chain
// (RL21) chip erase four words, poll repeated word
// (RL22) flash write: enter, address, data, latch pulse
// (RL23) page write word pulsed, then polled done
// (RL24) flash read returns low then high byte
// (RL25) eeprom write: enter, address, data, page pulse
// (RL26) eeprom read: enter, then address loads
// (RL27) programmer repeats poll until status bit one
// (RL28) leading latch word may be omitted
// (RL29) instruction decoded at update-ir, chain routed
`ifndef JTPD_REGS_SVH
`define JTPD_REGS_SVH

// instruction register
`define JTPD_IR_W           4
`define JTPD_IR_CAPTURE     4'h1
`define JTPD_IR_BYPASS      4'hf
`define JTPD_INS_DEV_RESET  4'hc
`define JTPD_INS_UNLOCK     4'h4
`define JTPD_INS_COMMAND    4'h5
`define JTPD_INS_PAGE_FILL  4'h6
`define JTPD_INS_PAGE_DUMP  4'h7

// data chains
`define JTPD_KEY_W          16
`define JTPD_UNLOCK_KEY     16'ha370
`define JTPD_CMD_W          15
`define JTPD_BYTE_W         8
`define JTPD_BIT_LAST       3'h7

`endif

// ---- hdl/jtpd_top.sv ----
// programming data path behind the jtag test access port
`timescale 1ns/1ps
`include "jtpd_regs.svh"

module jtpd_top
  import jtpd_pkg::*;
#(
  parameter int PAGE_BYTES = 128,
  parameter int TOUT_CYC0  = 0,
  parameter int TOUT_CYC1  = 16,
  parameter int TOUT_CYC2  = 256,
  parameter int TOUT_CYC3  = 4096
) (
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    nrst_i,
  // jtag pins
  input  wire logic                    tck_i,
  input  wire logic                    tms_i,
  input  wire logic                    tdi_i,
  output logic                         tdo_o,
  output logic                         tdo_oe_o,
  // device reset and programming mode
  input  wire logic [1:0]              tout_sel_i,
  output logic                         dev_reset_o,
  output logic                         prog_mode_o,
  // memory command interface
  output logic [`JTPD_CMD_W-1:0]       nvm_cmd_o,
  output logic                         nvm_cmd_upd_o,
  output logic                         nvm_exec_o,
  input  wire logic [`JTPD_CMD_W-1:0]  nvm_result_i,
  // page buffer interface
  output logic [$clog2(PAGE_BYTES)-1:0] page_addr_o,
  output logic [`JTPD_BYTE_W-1:0]      page_wr_data_o,
  output logic                         page_wr_o,
  input  wire logic [`JTPD_BYTE_W-1:0] page_rd_data_i
);

  localparam int AW = $clog2(PAGE_BYTES);
  localparam int TW = 24;

  // refuse sizes the counters cannot serve
  initial begin
    if (PAGE_BYTES < 2 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0)
      $error("PAGE_BYTES must be a power of two of at least 2");
    if (TOUT_CYC0 >= 2**TW || TOUT_CYC1 >= 2**TW ||
        TOUT_CYC2 >= 2**TW || TOUT_CYC3 >= 2**TW)
      $error("reset time-out does not fit the counter");
  end

  // pin synchronisers, two stages each
  logic [1:0] tck_sync_reg;
  logic [1:0] tms_sync_reg;
  logic [1:0] tdi_sync_reg;
  logic       tck_prev_reg;
  logic       tck_rise;
  logic       tck_fall;
  logic       tms_s;
  logic       tdi_s;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tck_sync_reg <= 2'h0;
      tms_sync_reg <= 2'h3;
      tdi_sync_reg <= 2'h3;
      tck_prev_reg <= 1'b0;
    end else begin
      tck_sync_reg <= {tck_sync_reg[0], tck_i};
      tms_sync_reg <= {tms_sync_reg[0], tms_i};
      tdi_sync_reg <= {tdi_sync_reg[0], tdi_i};
      tck_prev_reg <= tck_sync_reg[1];
    end
  end

  assign tck_rise = tck_sync_reg[1] & ~tck_prev_reg;
  assign tck_fall = ~tck_sync_reg[1] & tck_prev_reg;
  assign tms_s    = tms_sync_reg[1];
  assign tdi_s    = tdi_sync_reg[1];

  // tap controller
  jtpd_tap_t tap_reg;
  jtpd_tap_t tap_next;

  always_comb begin
    case (tap_reg)
      TAP_RESET:  tap_next = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_next = tms_s ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms_s ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR:  tap_next = tms_s ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms_s ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_next = tms_s ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms_s ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR:  tap_next = tms_s ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms_s ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:    tap_next = TAP_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tap_reg <= TAP_RESET;
    end else if (tck_rise) begin
      tap_reg <= tap_next;
    end
  end

  // per-state strobes, one clk_sys_i cycle on the tck rising edge
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;

  assign cap_dr = tck_rise && (tap_reg == TAP_CAP_DR);
  assign sh_dr  = tck_rise && (tap_reg == TAP_SH_DR);
  assign upd_dr = tck_rise && (tap_reg == TAP_UPD_DR);

  // instruction register, decoded at update-ir
  logic [`JTPD_IR_W-1:0] ir_sh_reg;
  logic [`JTPD_IR_W-1:0] ir_reg;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ir_sh_reg <= `JTPD_IR_BYPASS;
      ir_reg    <= `JTPD_IR_BYPASS;
    end else if (tck_rise) begin
      case (tap_reg)
        TAP_RESET:  ir_reg    <= `JTPD_IR_BYPASS;
        TAP_CAP_IR: ir_sh_reg <= `JTPD_IR_CAPTURE;
        TAP_SH_IR:  ir_sh_reg <= {tdi_s, ir_sh_reg[`JTPD_IR_W-1:1]}; // RL15
        TAP_UPD_IR: ir_reg    <= ir_sh_reg; // RL29
        default:    ir_reg    <= ir_reg;
      endcase
    end
  end

  logic sel_rst;
  logic sel_key;
  logic sel_cmd;
  logic sel_fill;
  logic sel_dump;

  // chain selection from the current instruction
  assign sel_rst  = (ir_reg == `JTPD_INS_DEV_RESET); // RL1
  assign sel_key  = (ir_reg == `JTPD_INS_UNLOCK);
  assign sel_cmd  = (ir_reg == `JTPD_INS_COMMAND) && prog_mode_o; // RL10
  assign sel_fill = (ir_reg == `JTPD_INS_PAGE_FILL) && prog_mode_o;
  assign sel_dump = (ir_reg == `JTPD_INS_PAGE_DUMP) && prog_mode_o;

  // one-bit reset chain and bypass bit
  logic rst_dr_reg;
  logic byp_reg;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_dr_reg <= 1'b0;
      byp_reg    <= 1'b0;
    end else begin
      if (sh_dr && sel_rst)
        rst_dr_reg <= tdi_s; // RL2
      if (cap_dr)
        byp_reg <= 1'b0;
      else if (sh_dr)
        byp_reg <= tdi_s;
    end
  end

  // reset time-out after the reset chain releases
  logic          rst_prev_reg;
  logic [TW-1:0] tout_cnt_reg;
  logic [TW-1:0] tout_load;

  always_comb begin
    case (tout_sel_i)
      2'h0:    tout_load = TW'(TOUT_CYC0);
      2'h1:    tout_load = TW'(TOUT_CYC1);
      2'h2:    tout_load = TW'(TOUT_CYC2);
      default: tout_load = TW'(TOUT_CYC3);
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_prev_reg <= 1'b0;
      tout_cnt_reg <= '0;
    end else begin
      rst_prev_reg <= rst_dr_reg;
      if (rst_dr_reg)
        tout_cnt_reg <= '0;
      else if (rst_prev_reg)
        tout_cnt_reg <= tout_load; // RL4
      else if (tout_cnt_reg != '0)
        tout_cnt_reg <= tout_cnt_reg - TW'(1);
    end
  end

  // chain one takes effect at once, time-out extends the release;
  // the release cycle bridges to the loaded count so reset never blips
  assign dev_reset_o = rst_dr_reg || rst_prev_reg || // RL3 RL4
                       (tout_cnt_reg != '0);

  // unlock key register and programming mode
  logic [`JTPD_KEY_W-1:0] key_reg;
  logic                   prog_reg;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      key_reg  <= '0; // RL9
      prog_reg <= 1'b0;
    end else if (sel_key) begin
      if (sh_dr)
        key_reg <= {tdi_s, key_reg[`JTPD_KEY_W-1:1]}; // RL6 RL15
      if (upd_dr)
        prog_reg <= (key_reg == `JTPD_UNLOCK_KEY); // RL7 RL8
    end
  end

  assign prog_mode_o = prog_reg;

  // command register, result in and command out
  logic [`JTPD_CMD_W-1:0] cmd_sh_reg;
  logic [`JTPD_CMD_W-1:0] cmd_reg;
  logic                   cmd_upd_reg;
  logic                   exec_arm_reg;
  logic                   exec_reg;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_sh_reg <= '0;
      cmd_reg    <= '0;
    end else if (sel_cmd) begin
      if (cap_dr)
        cmd_sh_reg <= nvm_result_i; // RL11
      else if (sh_dr)
        cmd_sh_reg <= {tdi_s, cmd_sh_reg[`JTPD_CMD_W-1:1]}; // RL12 RL15
      if (upd_dr)
        cmd_reg <= cmd_sh_reg; // RL13
    end
  end

  // update strobe and one execute clock at the first idle tck after each command update
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_upd_reg  <= 1'b0;
      exec_arm_reg <= 1'b0;
      exec_reg     <= 1'b0;
    end else begin
      cmd_upd_reg <= upd_dr && sel_cmd;
      exec_reg    <= 1'b0;
      if (upd_dr && sel_cmd)
        exec_arm_reg <= 1'b1;
      else if (tck_rise && tap_reg == TAP_IDLE && exec_arm_reg) begin
        exec_arm_reg <= 1'b0;
        exec_reg     <= 1'b1; // RL14
      end
    end
  end

  assign nvm_cmd_o     = cmd_reg; // RL21 RL22 RL23 RL24 RL25
  assign nvm_cmd_upd_o = cmd_upd_reg;
  assign nvm_exec_o    = exec_reg;

  // virtual page chains with an 8-bit shifter and byte counter
  logic [`JTPD_BYTE_W-1:0] pg_sh_reg;
  logic [2:0]              pg_bit_reg;
  logic [AW-1:0]           pg_addr_reg;
  logic [`JTPD_BYTE_W-1:0] wr_data_reg;
  logic                    wr_reg;
  logic                    byte_done;

  assign byte_done = (pg_bit_reg == `JTPD_BIT_LAST);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_sh_reg   <= '0;
      pg_bit_reg  <= '0;
      pg_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_reg      <= 1'b0;
    end else begin
      wr_reg <= 1'b0;
      if (cap_dr && (sel_fill || sel_dump)) begin
        // counters restart each scan, shifter keeps its contents
        pg_bit_reg  <= '0;
        pg_addr_reg <= '0;
      end else if (sh_dr && sel_fill) begin
        pg_bit_reg <= pg_bit_reg + 3'h1;
        pg_sh_reg  <= {tdi_s, pg_sh_reg[`JTPD_BYTE_W-1:1]}; // RL15 RL17
        if (byte_done) begin
          wr_data_reg <= {tdi_s, pg_sh_reg[`JTPD_BYTE_W-1:1]};
          wr_reg      <= 1'b1; // RL16
          pg_addr_reg <= pg_addr_reg + AW'(1);
        end
      end else if (sh_dr && sel_dump) begin
        pg_bit_reg <= pg_bit_reg + 3'h1;
        if (byte_done) begin
          pg_sh_reg   <= page_rd_data_i; // RL18 RL19
          pg_addr_reg <= pg_addr_reg + AW'(1);
        end else begin
          pg_sh_reg <= {1'b0, pg_sh_reg[`JTPD_BYTE_W-1:1]}; // RL19
        end
      end
    end
  end

  assign page_addr_o    = pg_addr_reg;
  assign page_wr_data_o = wr_data_reg;
  assign page_wr_o      = wr_reg;

  // tdo mux, updated on the tck falling edge
  logic tdo_bit;
  logic tdo_reg;
  logic tdo_oe_reg;

  always_comb begin
    if (tap_reg == TAP_SH_IR)
      tdo_bit = ir_sh_reg[0];
    else if (sel_rst)
      tdo_bit = rst_dr_reg;
    else if (sel_key)
      tdo_bit = key_reg[0];
    else if (sel_cmd)
      tdo_bit = cmd_sh_reg[0]; // RL12
    else if (sel_fill || sel_dump)
      tdo_bit = pg_sh_reg[0];
    else
      tdo_bit = byp_reg;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tdo_reg    <= 1'b0;
      tdo_oe_reg <= 1'b0;
    end else if (tck_fall) begin
      tdo_reg    <= tdo_bit;
      tdo_oe_reg <= (tap_reg == TAP_SH_DR) || (tap_reg == TAP_SH_IR);
    end
  end

  assign tdo_o    = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;

endmodule

// ---- verification/jtpd_asserts.sv ----
// port assertions for the jtag programming data path
`timescale 1ns/1ps
`include "jtpd_regs.svh"
module jtpd_asserts
  import jtpd_pkg::*;
#(
  parameter int PAGE_BYTES = 128
) (
  // clock, reset and jtag clock
  input wire logic                       clk_sys_i,
  input wire logic                       nrst_i,
  input wire logic                       tck_i,
  // device state
  input wire logic                       dev_reset_o,
  input wire logic                       prog_mode_o,
  // memory command side
  input wire logic [`JTPD_CMD_W-1:0]     nvm_cmd_o,
  input wire logic                       nvm_cmd_upd_o,
  input wire logic                       nvm_exec_o,
  // page buffer side
  input wire logic [$clog2(PAGE_BYTES)-1:0] page_addr_o,
  input wire logic                       page_wr_o
);
  localparam int AW = $clog2(PAGE_BYTES);
  logic armed_reg;

  // set by a command update, spent by the execute pulse
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) armed_reg <= 1'b0;
    else if (nvm_cmd_upd_o) armed_reg <= 1'b1;
    else if (nvm_exec_o) armed_reg <= 1'b0;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // a pulse falls on the next clock
  sequence s_drop(s);
    ##1 !s;
  endsequence
  // the jtag clock was high two cycles back
  sequence s_after_tck;
    $past(tck_i, 2);
  endsequence

  AST_UPD_PULSE: assert property (nvm_cmd_upd_o |-> s_drop(nvm_cmd_upd_o))
    else $error("command update pulse too long");
  AST_EXEC_PULSE: assert property (nvm_exec_o |-> s_drop(nvm_exec_o))
    else $error("execute pulse too long");
  AST_WR_PULSE: assert property (page_wr_o |-> s_drop(page_wr_o))
    else $error("page write pulse too long");
  AST_CMD_HOLD: assert property ($changed(nvm_cmd_o) |-> nvm_cmd_upd_o)
    else $error("command word moved without update");
  AST_EXEC_ARMED: assert property (nvm_exec_o |-> armed_reg)
    else $error("execute without a fresh command");
  AST_CMD_GATED: assert property (nvm_cmd_upd_o |-> prog_mode_o)
    else $error("command applied outside programming mode");
  AST_WR_GATED: assert property (page_wr_o |-> prog_mode_o)
    else $error("page write outside programming mode");
  AST_ADDR_STEP: assert property (page_wr_o |->
    page_addr_o == AW'($past(page_addr_o) + 1))
    else $error("page address did not step by one");
  AST_PROG_TCK: assert property ($changed(prog_mode_o) |-> s_after_tck)
    else $error("programming mode moved without tck rise");
  AST_RST_TCK: assert property ($rose(dev_reset_o) |-> s_after_tck)
    else $error("device reset rose without tck rise");
endmodule

bind jtpd_top jtpd_asserts #(.PAGE_BYTES(PAGE_BYTES)) u_asserts (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck_i),
  .dev_reset_o(dev_reset_o), .prog_mode_o(prog_mode_o),
  .nvm_cmd_o(nvm_cmd_o), .nvm_cmd_upd_o(nvm_cmd_upd_o),
  .nvm_exec_o(nvm_exec_o), .page_addr_o(page_addr_o),
  .page_wr_o(page_wr_o)
);

// ---- verification/jtpd_prog_model.sv ----
// jtag programmer model driving the test access port
`timescale 1ns/1ps
module jtpd_prog_model (
  // jtag pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic tdo_last = 1'b0;
  logic tdo_w;

  // a released tdo reads as the inverse of its last value
  assign tdo_w = tdo_oe_i ? tdo_i : ~tdo_last;
  always @(posedge tck_o) tdo_last <= tdo_w;
  // tck rests low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // one 200 ns tck period, tdo taken after the rise
  task automatic clk1(input logic t, input logic d, output logic o);
    tms_o = t;
    tdi_o = d;
    #100;
    tck_o = 1'b1;
    #50;
    o = tdo_w;
    #50;
    tck_o = 1'b0;
  endtask

  // test-logic-reset, then run-test/idle
  task automatic tap_reset();
    logic o;
    #3;
    repeat (5) clk1(1'b1, 1'b0, o);
    clk1(1'b0, 1'b0, o);
  endtask

  // single device chain: n bits through ir or dr, back to idle
  task automatic scan(input logic ir, input logic [255:0] din,
                      input int n, output logic [255:0] dout);
    logic o;
    dout = '0;
    clk1(1'b1, 1'b0, o);
    if (ir) clk1(1'b1, 1'b0, o);
    clk1(1'b0, 1'b0, o);
    clk1(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) clk1(i == n - 1, din[i], dout[i]);
    clk1(1'b1, 1'b0, o);
    clk1(1'b0, 1'b0, o);
    clk1(1'b0, 1'b0, o);
  endtask
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the jtag programming data path
`timescale 1ns/1ps
module testbench;
  localparam int PB = 16;
  logic        clk_sys_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe, dev_reset, prog_mode;
  logic        upd, exec, wr;
  logic [1:0]  tout_sel  = 2'h0;
  logic [14:0] cmd, w;
  logic [14:0] result    = 15'h0;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata;
  logic [15:0] key;
  logic [7:0]  fill_mem [PB];
  logic [7:0]  dump_mem [PB];
  logic [14:0] words [11] = '{15'h2380, 15'h3380, 15'h2310, 15'h0755,
    15'h7700, 15'h3500, 15'h2302, 15'h3600, 15'h2311, 15'h3100, 15'h2303};
  logic [255:0] din, dout;
  int          fails = 0, check_count = 0, n_upd = 0, n_exec = 0;
  int          n_wr = 0, u, e, el;
  time         t0, t_fall;

  always #12.5 clk_sys_i = ~clk_sys_i;

  jtpd_top #(.PAGE_BYTES(PB), .TOUT_CYC0(0), .TOUT_CYC1(40),
    .TOUT_CYC2(80), .TOUT_CYC3(120)) dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .tout_sel_i(tout_sel),
    .dev_reset_o(dev_reset), .prog_mode_o(prog_mode), .nvm_cmd_o(cmd),
    .nvm_cmd_upd_o(upd), .nvm_exec_o(exec), .nvm_result_i(result),
    .page_addr_o(addr), .page_wr_data_o(wdata), .page_wr_o(wr),
    .page_rd_data_i(rdata));
  jtpd_prog_model prog (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // page buffer read side and pulse counters
  assign rdata = dump_mem[addr];
  always @(negedge dev_reset) t_fall = $time;
  always @(posedge clk_sys_i) begin
    if (upd === 1'b1) n_upd++;
    if (exec === 1'b1) n_exec++;
    if (wr === 1'b1) begin
      fill_mem[addr - 4'h1] = wdata;
      n_wr++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic ir(input logic [3:0] ins);
    prog.scan(1'b1, 256'(ins), 4, dout);
    check(dout[3:0], 4'h1);
  endtask
  task automatic dr(input logic [255:0] d, input int n);
    prog.scan(1'b0, d, n, dout);
  endtask

  // watchdog
  initial begin
    #1000000;
    fails++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(37));
    repeat (16) @(posedge clk_sys_i);
    @(negedge clk_sys_i) nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    check(prog_mode, 1'b0);
    prog.tap_reset();
    // reset chain under every time-out select
    ir(4'hc);
    for (int s = 0; s < 4; s++) begin
      @(negedge clk_sys_i) tout_sel = s[1:0];
      dr(256'h1, 1);
      check(dev_reset, 1'b1);
      fork
        dr(256'h0, 1);
        begin
          // fourth tck rise is the one that shifts the zero in
          repeat (4) @(posedge tck);
          t0 = $time;
        end
      join
      repeat (130) @(negedge clk_sys_i);
      el = (t_fall - t0) / 25;
      check(el >= 40 * s && el <= 40 * s + 6, 1'b1);
    end
    dr(256'h1, 1);
    // near miss, random, exact, random, exact key
    ir(4'h4);
    for (int k = 0; k < 5; k++) begin
      key = k[0] ? 16'($urandom) : (k == 0 ? 16'ha371 : 16'ha370);
      dr(256'(key), 16);
      check(prog_mode, key === 16'ha370);
    end
    // documented command words, then random ones
    ir(4'h5);
    for (int i = 0; i < 14; i++) begin
      w = (i < 11) ? words[i] : 15'($urandom);
      @(negedge clk_sys_i) result = 15'($urandom);
      u = n_upd;
      e = n_exec;
      dr(256'(w), 15);
      check(dout[14:0], result);
      check(cmd, w);
      check(n_upd - u, 1);
      check(n_exec - e, 1);
    end
    // chip erase poll: repeat the poll word until status bit 9 is set
    dout = '0;
    u = n_upd;
    for (int p = 0; p < 8 && dout[9] !== 1'b1; p++) begin
      @(negedge clk_sys_i) result = (p == 3) ? 15'h0200 : 15'h0000;
      dr(256'h3380, 15);
    end
    check(n_upd - u, 4);
    check(dout[14:0], 15'h0200);
    // page fill then page dump, device alone in the chain
    ir(4'h6);
    for (int i = 0; i < 256; i++) din[i] = 1'($urandom);
    u = n_wr;
    dr(din, PB * 8);
    check(n_wr - u, PB);
    for (int i = 0; i < PB; i++) check(fill_mem[i], din[8*i +: 8]);
    ir(4'h7);
    for (int i = 0; i < PB; i++) dump_mem[i] = 8'($urandom);
    for (int i = 0; i < 256; i++) din[i] = 1'($urandom);
    dr(din, PB * 8 + 8);
    for (int i = 0; i < PB; i++) check(dout[8*i+8 +: 8], dump_mem[i]);
    // leave programming, commands refused, programming mode cleared by reset
    ir(4'h4);
    dr(256'h0, 16);
    check(prog_mode, 1'b0);
    ir(4'h5);
    u = n_upd;
    dr(256'h2380, 15);
    check(n_upd - u, 0);
    ir(4'h4);
    dr(256'ha370, 16);
    check(prog_mode, 1'b1);
    @(negedge clk_sys_i) nrst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    check(prog_mode, 1'b0);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    tally_and_finish();
  end
endmodule
